// ==== core/psw_power_ctrl.sv ====
// power sleep wakeup control with apb register slave
// =====================================================================
`timescale 1ns/1ps
`default_nettype none
`include "psw_consts.svh"
module psw_power_ctrl
  import psw_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic osc_stable, // oscillator settled, async
  input wire logic synth_locked, // loop lock, async
  input wire logic [15:0] supply_mv, // supply in millivolts, same clock
  output logic osc_on, // crystal oscillator enable
  output logic synth_on, // synthesizer enable
  output logic synth_cal, // calibration start pulse
  output logic amp_on, // power amplifier enable
  output logic batt_det_on, // battery detector enable
  output logic clk_out_on, // clock output enable
  output logic sleeping, // chip in sleep mode
  output logic irq // level interrupt
);
  typedef struct packed {
    logic [15:0] sleep_clock_command;
    logic [15:0] wakeup_period;
    logic [15:0] battery_threshold;
    logic [15:0] power_management;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    psw_state_t state;
    logic [7:0] drain;
    logic [2:0] stab_sync;
    logic [2:0] lock_sync;
    logic stab;
    logic lock;
    logic low_battery_flag;
    logic synth_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_on;
    logic synth_on;
    logic synth_cal;
    logic amp_on;
    logic batt_det_on;
    logic clk_out_on;
    logic sleeping;
    logic irq;
  } psw_top_t;
  psw_top_t q, d;

  logic wake_pulse;
  logic wr, rd;
  logic [15:0] wdat;
  logic [15:0] thr_mv;
  logic [7:0] ev;
  logic auto_os, auto_pa;
  logic next_osc, next_synth, next_amp;

  assign wr = psel && penable && pwrite && !q.pready;
  assign rd = psel && penable && !pwrite && !q.pready;
  assign wdat = pwdata[15:0];
  assign auto_os = q.power_management[`PSW_PM_AUTO_OS];
  assign auto_pa = q.power_management[`PSW_PM_AUTO_PA];
  // threshold: code * 100 mV + 2200 mV
  assign thr_mv = `PSW_BASE_MV +
    16'(q.battery_threshold[4:0]) * `PSW_STEP_MV;

  // =================================================================
  // wake timer
  psw_wake_timer u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .run(q.power_management[`PSW_PM_WAKE] && !q.sleeping),
    .exponent(q.wakeup_period[12:8]),
    .multiplier(q.wakeup_period[7:0]),
    .expired(wake_pulse)
  );

  always_comb begin
    d = q;
    ev = 8'h00;
    next_osc = 1'b0;
    next_synth = 1'b0;
    next_amp = 1'b0;
    // ===============================================================
    // pin synchronisers, third and second stages must agree
    d.stab_sync = {q.stab_sync[1:0], osc_stable};
    d.lock_sync = {q.lock_sync[1:0], synth_locked};
    if (q.stab_sync[2] == q.stab_sync[1]) begin
      d.stab = q.stab_sync[2];
    end
    if (q.lock_sync[2] == q.lock_sync[1]) begin
      d.lock = q.lock_sync[2];
    end
    // ===============================================================
    // apb slave, one wait state: ready the cycle after the first access cycle
    d.pready = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    if (rd || wr) begin
      d.prdata = 32'h0;
      case (paddr)
        `PSW_OFF_SLEEP, `PSW_OFF_WAKE, `PSW_OFF_BATT, `PSW_OFF_PWR,
        `PSW_OFF_IRQ_CLR, `PSW_OFF_XMIT: begin
          // write-only registers read as zero
        end
        `PSW_OFF_STAT: begin
          d.prdata = {24'h0, q.irq_status};
        end
        `PSW_OFF_IRQ_EN: begin
          d.prdata = {24'h0, q.irq_enable};
          if (wr) begin
            d.irq_enable = pwdata[7:0];
          end
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end
    // command words only land when their code bits match;
    // a mismatching code is dropped silently, as a serial host
    // would see no error either, so software must read back
    // the outputs when in doubt
    if (wr && paddr == `PSW_OFF_SLEEP &&
        wdat[15:8] == `PSW_CMD_SLEEP) begin
      d.sleep_clock_command = wdat;
      d.drain = wdat[7:0];
      d.state = PSW_DRAIN;
    end
    if (wr && paddr == `PSW_OFF_WAKE &&
        wdat[15:13] == `PSW_CMD_WAKE) begin
      d.wakeup_period = wdat;
    end
    if (wr && paddr == `PSW_OFF_BATT &&
        wdat[15:8] == `PSW_CMD_BATT) begin
      d.battery_threshold = wdat;
    end
    if (wr && paddr == `PSW_OFF_PWR &&
        wdat[15:8] == `PSW_CMD_PWR) begin
      d.power_management = wdat;
      if (q.state == PSW_ASLEEP) begin
        d.state = PSW_IDLE;
      end
    end
    // ===============================================================
    // automatic transmit chain
    case (q.state)
      PSW_IDLE: begin
        if (wr && paddr == `PSW_OFF_XMIT && auto_os) begin
          d.state = PSW_OSC_WAIT;
        end
      end
      PSW_OSC_WAIT: begin
        next_osc = 1'b1;
        if (q.stab) begin
          d.state = PSW_LOCK_WAIT;
        end
      end
      PSW_LOCK_WAIT: begin
        next_osc = 1'b1;
        next_synth = 1'b1;
        if (q.lock) begin
          d.state = PSW_ON;
        end
      end
      PSW_ON: begin
        next_osc = 1'b1;
        next_synth = 1'b1;
        next_amp = auto_pa && q.lock;
        if (!auto_os) begin
          d.state = PSW_IDLE;
        end
      end
      PSW_DRAIN: begin
        // amplifier and synth already off; clock keeps running
        // so the host still sees its trailing cycles; the drain
        // counter reaches zero once more before sleep, hence
        // one cycle beyond the programmed count
        if (q.drain == 8'h00) begin
          d.state = PSW_ASLEEP;
          ev[`PSW_ST_SLEEP] = 1'b1;
        end else begin
          d.drain = q.drain - 8'h01;
        end
      end
      PSW_ASLEEP: begin
      end
      default: begin
        d.state = PSW_IDLE;
      end
    endcase
    if (q.state == PSW_DRAIN || q.state == PSW_ASLEEP ||
        d.state == PSW_DRAIN) begin
      d.osc_on = (d.state == PSW_DRAIN);
      d.synth_on = 1'b0;
      d.amp_on = 1'b0;
    end else begin
      d.osc_on = q.power_management[`PSW_PM_XTAL] || next_osc;
      d.synth_on = q.power_management[`PSW_PM_SYNTH] || next_synth;
      d.amp_on = q.power_management[`PSW_PM_PA] || next_amp;
    end
    d.sleeping = (d.state == PSW_ASLEEP);
    // every rising enable restarts calibration
    d.synth_prev = d.synth_on;
    d.synth_cal = d.synth_on && !q.synth_prev;
    d.clk_out_on = !q.power_management[`PSW_PM_CLKDIS] &&
      !d.sleeping;
    // ===============================================================
    // battery detector with 50 mV margin
    d.batt_det_on = q.power_management[`PSW_PM_BATT];
    if (!q.batt_det_on) begin
      d.low_battery_flag = 1'b0;
    end else if (supply_mv + `PSW_HYST_MV < thr_mv) begin
      d.low_battery_flag = 1'b1;
    end else if (supply_mv >= thr_mv) begin
      d.low_battery_flag = 1'b0;
    end
    // ===============================================================
    // interrupts: set beats clear
    ev[`PSW_ST_WAKE] = wake_pulse;
    ev[`PSW_ST_LOCK] = q.lock && !q.lock_sync[2] ? 1'b0 :
      (d.lock && !q.lock);
    ev[`PSW_ST_LOWBAT] = d.low_battery_flag && !q.low_battery_flag;
    if (wr && paddr == `PSW_OFF_IRQ_CLR) begin
      d.irq_status = q.irq_status & ~pwdata[7:0];
    end
    d.irq_status = d.irq_status | ev;
    d.irq_status[`PSW_ST_LOWBAT - 1] = 1'b0;
    d.irq = |(d.irq_status & d.irq_enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.sleep_clock_command <= `PSW_RST_SLEEP;
      q.wakeup_period <= `PSW_RST_WAKE;
      q.battery_threshold <= `PSW_RST_BATT;
      q.power_management <= `PSW_RST_PWR;
      q.state <= PSW_IDLE;
      q.clk_out_on <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign osc_on = q.osc_on;
  assign synth_on = q.synth_on;
  assign synth_cal = q.synth_cal;
  assign amp_on = q.amp_on;
  assign batt_det_on = q.batt_det_on;
  assign clk_out_on = q.clk_out_on;
  assign sleeping = q.sleeping;
  assign irq = q.irq;
endmodule
`default_nettype wire

// ==== core/psw_wake_timer.sv ====
// wake-up interval timer: multiplier times two to the exponent
`timescale 1ns/1ps
`default_nettype none
`include "psw_consts.svh"
module psw_wake_timer
  import psw_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // timer enable level
  input wire logic [4:0] exponent, // interval exponent
  input wire logic [7:0] multiplier, // interval multiplier
  output logic expired // one-cycle pulse at interval end
);
  typedef struct packed {
    logic [6:0] div;
    logic [39:0] count;
    logic armed;
    logic expired;
  } psw_wt_t;
  psw_wt_t q, d;
  logic [39:0] limit;

  // =================================================================
  // interval
  assign limit = {32'h0, multiplier} << exponent;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (!run) begin
      d = '0;
    end else if (q.armed) begin
      if (q.div == `PSW_TICK_DIV) begin
        d.div = 7'h00;
        if (q.count + 40'h1 >= limit) begin
          d.expired = 1'b1;
          d.armed = 1'b0; // one shot until run drops, except a limit of 0 or 1, which rearms itself
        end else begin
          d.count = q.count + 40'h1;
        end
      end else begin
        d.div = q.div + 7'h01;
      end
    end
    if (!run) begin
      d.armed = 1'b0;
    end else if (!q.armed && q.count == 40'h0 && q.div == 7'h00 &&
                 !q.expired) begin
      d.armed = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign expired = q.expired;
endmodule
`default_nettype wire

// ==== shared/psw_consts.svh ====
// constants of the power sleep wakeup control block
`ifndef PSW_CONSTS_SVH
`define PSW_CONSTS_SVH
// =====================================================================
// apb register byte offsets
`define PSW_OFF_SLEEP 12'h000
`define PSW_OFF_WAKE 12'h004
`define PSW_OFF_BATT 12'h008
`define PSW_OFF_PWR 12'h00c
`define PSW_OFF_STAT 12'h010
`define PSW_OFF_IRQ_EN 12'h014
`define PSW_OFF_IRQ_CLR 12'h018
`define PSW_OFF_XMIT 12'h01c
// =====================================================================
// power-on defaults
`define PSW_RST_SLEEP 16'hc400
`define PSW_RST_WAKE 16'he000
`define PSW_RST_BATT 16'hc200
`define PSW_RST_PWR 16'hc000
// =====================================================================
// command code checks
`define PSW_CMD_SLEEP 8'hc4
`define PSW_CMD_WAKE 3'h7
`define PSW_CMD_BATT 8'hc2
`define PSW_CMD_PWR 8'hc0
// =====================================================================
// power management bits
`define PSW_PM_AUTO_OS 7
`define PSW_PM_AUTO_PA 6
`define PSW_PM_XTAL 5
`define PSW_PM_SYNTH 4
`define PSW_PM_PA 3
`define PSW_PM_BATT 2
`define PSW_PM_WAKE 1
`define PSW_PM_CLKDIS 0
// =====================================================================
// status / interrupt bits
`define PSW_ST_WAKE 0
`define PSW_ST_SLEEP 1
`define PSW_ST_LOCK 2
`define PSW_ST_LOWBAT 5
// hysteresis in millivolts, steps of 100 mV from 2200 mV
`define PSW_HYST_MV 16'd50
`define PSW_BASE_MV 16'd2200
`define PSW_STEP_MV 16'd100
// timer tick: one wake unit of 1 us at 100 MHz
`define PSW_TICK_DIV 7'd99
`endif

// ==== shared/psw_pkg.sv ====
// types of the power sleep wakeup control block
package psw_pkg;
  typedef enum logic [2:0] {
    PSW_IDLE, PSW_OSC_WAIT, PSW_LOCK_WAIT, PSW_ON, PSW_DRAIN, PSW_ASLEEP
  } psw_state_t;
endpackage

// ==== test/psw_power_ctrl_sva.sv ====
// assertions on the ports of the power control block
`timescale 1ns/1ps
`default_nettype none
module psw_power_ctrl_sva (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic osc_on, // oscillator enable
  input wire logic synth_on, // synth enable
  input wire logic synth_cal, // calibration pulse
  input wire logic amp_on, // amplifier enable
  input wire logic batt_det_on, // detector enable
  input wire logic clk_out_on, // clock output enable
  input wire logic sleeping // sleep mode
);
  // =========
  // write decode
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] wd;
  wire logic take;
  wire logic pm;
  wire logic sl;
  assign take = psel && penable && pready && pwrite;
  // auto chain bits clear, so bits map straight to outputs
  assign pm = take && paddr == 12'h00c && pwdata[15:6] == 10'h300;
  assign sl = take && paddr == 12'h000 && pwdata[15:8] == 8'hc4;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wd <= 16'h0000;
    else if (take)
      wd <= pwdata[15:0];
  end
  a_xtal_bit: assert property (pm |-> ##2 osc_on == wd[5])
    else $error("oscillator enable mismatch");
  a_synth_bit: assert property (pm |-> ##2 synth_on == wd[4])
    else $error("synth enable mismatch");
  a_amp_bit: assert property (pm |-> ##2 amp_on == wd[3])
    else $error("amplifier enable mismatch");
  a_batt_bit: assert property (pm |-> ##2 batt_det_on == wd[2])
    else $error("detector enable mismatch");
  a_clk_bit: assert property (pm |-> ##2 clk_out_on == !wd[0])
    else $error("clock output mismatch");
  a_cal_pulse: assert property ($rose(synth_on) |-> ##[0:1] synth_cal)
    else $error("no calibration on synth enable");
  a_cal_single: assert property (synth_cal |=> !synth_cal)
    else $error("calibration pulse too long");
  a_sleep_drops: assert property (sl |-> ##2 !amp_on && !synth_on)
    else $error("amplifier or synth left on");
  a_sleep_quiet: assert property (sleeping |-> !osc_on && !clk_out_on)
    else $error("oscillator running in sleep");
  // drain lands on the ready edge, so sleep follows count plus one cycles later; counts of 3 up are checked
  a_sleep_wait: assert property (sl && pwdata[7:0] > 8'h02 |=> !sleeping [*2])
    else $error("sleep entered early");
  cover property (sl);
  cover property ($rose(sleeping));
  cover property ($rose(amp_on));
endmodule
bind psw_power_ctrl psw_power_ctrl_sva i_sva (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .osc_on, .synth_on, .synth_cal,
  .amp_on, .batt_det_on, .clk_out_on, .sleeping);
`default_nettype wire

// ==== test/psw_power_ctrl_test.sv ====
// testbench of the power control block
`timescale 1ns/1ps
`default_nettype none
module psw_power_ctrl_test;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [15:0] supply_mv = 16'd3300;
  logic pready, pslverr, osc_stable, synth_locked, osc_on, synth_on;
  logic synth_cal, amp_on, batt_det_on, clk_out_on, sleeping, irq;
  logic [7:0] slp [2] = '{8'h00, 8'h05};
  int err_count = 0, total_checks = 0, n;
  always #5 clk = ~clk;
  psw_power_ctrl i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .osc_stable, .synth_locked,
    .supply_mv, .osc_on, .synth_on, .synth_cal, .amp_on, .batt_det_on,
    .clk_out_on, .sleeping, .irq);
  psw_rf_model i_rf (.clk, .osc_on, .synth_on, .osc_stable, .synth_locked);
  // =========
  // tasks
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t in a check", $time);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    xfer(a, 1'b1, {16'h0000, d});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task give_verdict;
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(10000);
    err_count++;
    give_verdict();
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    chk({osc_on, amp_on, clk_out_on} === 3'b001);
    wr(12'h00c, 16'hc120);
    cyc(3);
    chk(osc_on === 1'b0);
    wr(12'h00c, 16'hc03d);
    cyc(3);
    chk({osc_on, synth_on, amp_on, batt_det_on, clk_out_on} === 5'b11110);
    wr(12'h00c, 16'hc020);
    wr(12'h00c, 16'hc030);
    n = 0;
    repeat (4) begin
      @(posedge clk);
      n += synth_cal;
    end
    chk(n == 1);
    foreach (slp[i]) begin
      wr(12'h00c, 16'hc038);
      wr(12'h000, {8'hc4, slp[i]});
      n = 0;
      repeat (300) begin
        @(posedge clk);
        if (sleeping === 1'b1)
          break;
        n += osc_on & !amp_on & !synth_on;
      end
      // first drain cycle stands during the transfer's release edge
      chk(n == slp[i]);
      chk({osc_on, clk_out_on, sleeping} === 3'b001);
    end
    // twelve ticks of 100 cycles, tick phase unknown
    wr(12'h018, 16'h0027);
    wr(12'h004, 16'he203);
    wr(12'h00c, 16'hc002);
    cyc(1050);
    xfer(12'h010, 1'b0, 32'h0);
    chk(rd[0] === 1'b0);
    cyc(300);
    xfer(12'h010, 1'b0, 32'h0);
    chk(rd[0] === 1'b1);
    wr(12'h018, 16'h0027);
    wr(12'h00c, 16'hc000);
    wr(12'h014, 16'h0020);
    xfer(12'h014, 1'b0, 32'h0);
    chk(rd[7:0] === 8'h20);
    wr(12'h008, 16'hc205);
    wr(12'h00c, 16'hc004);
    supply_mv <= 16'd2660;
    cyc(10);
    chk(irq === 1'b0);
    supply_mv <= 16'd2640;
    cyc(10);
    chk(irq === 1'b1);
    xfer(12'h010, 1'b0, 32'h0);
    chk(rd[5] === 1'b1);
    supply_mv <= 16'd3300;
    wr(12'h018, 16'h0020);
    cyc(2);
    chk(irq === 1'b0);
    wr(12'h00c, 16'hc000);
    supply_mv <= 16'd2000;
    cyc(10);
    chk(irq === 1'b0);
    wr(12'h00c, 16'hc0c0);
    wr(12'h01c, 16'hc600);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (synth_on === 1'b1 && n == 0) begin
        n = 1;
        chk(osc_stable === 1'b1);
      end
      if (amp_on === 1'b1)
        break;
    end
    chk({synth_locked, amp_on} === 2'b11);
    xfer(12'h020, 1'b0, 32'h0);
    chk(er === 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== test/psw_rf_model.sv ====
// model of the analog side: oscillator settling and loop lock
`timescale 1ns/1ps
`default_nettype none
module psw_rf_model #(
  parameter int OSC_DLY = 20,
  parameter int LOCK_DLY = 30
) (
  input wire logic clk, // clock
  input wire logic osc_on, // oscillator enable
  input wire logic synth_on, // synth enable
  output logic osc_stable, // oscillator settled
  output logic synth_locked // loop locked
);
  // =========
  // settle counters
  int oc = 0;
  int lc = 0;
  // no lock without the crystal reference
  always @(posedge clk) begin
    oc <= osc_on ? oc + 1 : 0;
    lc <= (synth_on && osc_stable) ? lc + 1 : 0;
  end
  assign osc_stable = oc >= OSC_DLY;
  assign synth_locked = lc >= LOCK_DLY;
endmodule
`default_nettype wire
